// file: hdl/lnbsl_pkg.sv
package lnbsl_pkg;

  // ----------------------------------------------------------------
  // register map and bus constants
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_INDEX      = 8'h00;
  localparam logic [7:0] STAT_INDEX      = 8'h00;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [4:0] TARGET_ID_FIXED = 5'h02;
  localparam int         SYNC_STAGES     = 2;

  // ----------------------------------------------------------------
  // status layout
  // ----------------------------------------------------------------
  localparam int         STAT_UV_BIT     = 0;
  localparam int         STAT_OC_BIT     = 1;
  localparam int         STAT_TH_BIT     = 2;
  localparam int         FAULT_COUNT     = 3;

  typedef enum logic [1:0] {
    KIND_ADDR  = 2'b00,
    KIND_INDEX = 2'b01,
    KIND_DATA  = 2'b10
  } lnbsl_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RECV   = 3'b001,
    ST_CHECK  = 3'b010,
    ST_ACK    = 3'b011,
    ST_SEND   = 3'b100,
    ST_MACK   = 3'b101,
    ST_IGNORE = 3'b110
  } lnbsl_state_e;

endpackage : lnbsl_pkg

// file: hdl/lnbsl_sync.sv
`timescale 1ns/1ps
module lnbsl_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // two-flop synchroniser, first stage read only by the second
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      // reset to the idle level of the input, so no false edge follows reset
      meta_r   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : lnbsl_sync

// file: hdl/lnbsl_fault_latch.sv
`timescale 1ns/1ps
module lnbsl_fault_latch
  import lnbsl_pkg::*;
#(
  parameter int N = FAULT_COUNT
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [N-1:0] fault_level,
  input  wire logic         clear_pulse,
  input  wire logic [N-1:0] clear_mask,
  output logic      [N-1:0] latched_r,
  output logic              irq_r
);

  // ----------------------------------------------------------------
  // sticky fault bits, a live fault beats the clear
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge clk) begin
        if (reset) begin
          latched_r[g] <= 1'b0;
        end else if (fault_level[g]) begin
          latched_r[g] <= 1'b1;
        end else if (clear_pulse && clear_mask[g]) begin
          latched_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(fault_level | (latched_r & ~({N{clear_pulse}} & clear_mask)));
    end
  end

endmodule : lnbsl_fault_latch

// file: hdl/lnbsl_slave.sv
`timescale 1ns/1ps
// Notes on behaviour
// - clock and data driven open-drain only
// - data changes only while clock low
// - acknowledge good byte by pulling data low
// - bad byte leaves data high: negative acknowledge
// - start falls, stop rises, clock high
// - start or stop restarts the sequence
// - write: address, index, control data bytes
// - address MSB first, write bit zero
// - address upper five fixed, lower two strapped
// - write index must be all zeros
// - control byte acknowledged, then register updated
// - read: address, index, repeated address, status
// - read index must be all zeros
// - repeated address with read bit acknowledged
// - status shifted out MSB first
// - faults latched, interrupt asserted
// - only master acknowledge releases latched faults
module lnbsl_slave
  import lnbsl_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  output logic            SCL_OUT,
  output logic            SCL_OE,
  input  wire logic [1:0] ADDR_SEL,
  input  wire logic       UNDERVOLTAGE_FAULT,
  input  wire logic       OVERCURRENT_FAULT,
  input  wire logic       THERMAL_FAULT,
  output logic      [7:0] CONTROL_SETTINGS,
  output logic            CONTROL_STROBE,
  output logic      [7:0] FAULT_STATUS,
  output logic            IRQ_N_OUT,
  output logic            IRQ_N_OE
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0]             line_sync;
  logic [1:0]             strap_sync;
  logic [FAULT_COUNT-1:0] fault_sync;
  logic                   scl_h;
  logic                   sda_h;

  lnbsl_sync #(.WIDTH(2)) u_line_sync (
    .clk      (CORE_CLK),
    .reset    (RESET),
    .async_in ({SCL, SDA_IN}),
    .sync_out (line_sync)
  );

  lnbsl_sync #(.WIDTH(2)) u_strap_sync (
    .clk      (CORE_CLK),
    .reset    (RESET),
    .async_in (ADDR_SEL),
    .sync_out (strap_sync)
  );

  // faults idle low; a high reset level would latch every fault after reset
  lnbsl_sync #(.WIDTH(FAULT_COUNT), .RESET_VAL('0)) u_fault_sync (
    .clk      (CORE_CLK),
    .reset    (RESET),
    .async_in ({THERMAL_FAULT, OVERCURRENT_FAULT, UNDERVOLTAGE_FAULT}),
    .sync_out (fault_sync)
  );

  assign scl_h = line_sync[1];
  assign sda_h = line_sync[0];

  // ----------------------------------------------------------------
  // edge and condition detection
  // ----------------------------------------------------------------
  logic scl_d_r;
  logic sda_d_r;
  logic sda_dd_r;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
      sda_dd_r <= 1'b1;
    end else begin
      scl_d_r  <= scl_h;
      sda_d_r  <= sda_h;
      sda_dd_r <= sda_d_r;
    end
  end

  assign scl_rise   = scl_h & ~scl_d_r;
  assign scl_fall   = ~scl_h & scl_d_r;
  // both conditions need the clock high in the two samples after the data edge
  // data runs one sample behind, so a zero-hold data change right after
  // the clock falls is never taken for a start or stop
  assign start_cond = scl_h & scl_d_r & sda_dd_r & ~sda_d_r;
  assign stop_cond  = scl_h & scl_d_r & ~sda_dd_r & sda_d_r;

  // ----------------------------------------------------------------
  // strap capture, once after reset release
  // ----------------------------------------------------------------
  logic [1:0] strap_r;
  logic       strap_taken_r;
  logic [1:0] strap_wait_r;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      strap_r       <= 2'h0;
      strap_taken_r <= 1'b0;
      strap_wait_r  <= 2'h0;
    end else if (!strap_taken_r) begin
      // the synchroniser must refill with the pin level before the capture
      if (strap_wait_r == 2'(SYNC_STAGES)) begin
        strap_r       <= strap_sync;
        strap_taken_r <= 1'b1;
      end else begin
        strap_wait_r <= strap_wait_r + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // fault latch
  // ----------------------------------------------------------------
  logic [FAULT_COUNT-1:0] status_bits;
  logic                   irq_level;
  logic                   clear_r;
  logic [FAULT_COUNT-1:0] snap_r;
  logic [7:0]             status_byte;

  lnbsl_fault_latch #(.N(FAULT_COUNT)) u_fault_latch (
    .clk         (CORE_CLK),
    .reset       (RESET),
    .fault_level (fault_sync),
    .clear_pulse (clear_r),
    .clear_mask  (snap_r),
    .latched_r   (status_bits),
    .irq_r       (irq_level)
  );

  // unused upper bits read as zero
  assign status_byte = {{(8-FAULT_COUNT){1'b0}}, status_bits};

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  lnbsl_state_e state_r;
  lnbsl_kind_e  kind_r;
  logic [2:0]   cnt_r;
  logic [7:0]   shift_r;
  logic         read_dir_r;
  logic         sda_oe_r;
  logic [7:0]   ctrl_r;
  logic         ctrl_stb_r;
  logic         addr_match;
  logic         ack_good;

  // ----------------------------------------------------------------
  // acknowledge decision
  // ----------------------------------------------------------------
  // upper five bits fixed, lower two from strap, eighth bit is direction
  assign addr_match = (shift_r[7:3] == TARGET_ID_FIXED) && (shift_r[2:1] == strap_r);

  always_comb begin
    case (kind_r)
      KIND_ADDR:  ack_good = addr_match;
      KIND_INDEX: ack_good = (shift_r == (read_dir_r ? STAT_INDEX : CTRL_INDEX));
      KIND_DATA:  ack_good = 1'b1;
      default:    ack_good = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_r    <= ST_IDLE;
      kind_r     <= KIND_ADDR;
      cnt_r      <= 3'h0;
      shift_r    <= 8'h00;
      read_dir_r <= 1'b0;
      sda_oe_r   <= 1'b0;
      snap_r     <= '0;
      clear_r    <= 1'b0;
    end else begin
      clear_r <= 1'b0;
      if (start_cond) begin
        // restart at the address byte, dropping any drive on data
        state_r  <= ST_RECV;
        kind_r   <= KIND_ADDR;
        cnt_r    <= 3'h0;
        sda_oe_r <= 1'b0;
      end else if (stop_cond) begin
        state_r  <= ST_IDLE;
        cnt_r    <= 3'h0;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_RECV: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_h};
              cnt_r   <= cnt_r + 3'h1;
              if (cnt_r == 3'h7) begin
                state_r <= ST_CHECK;
              end
            end
          end
          ST_CHECK: begin
            // decide on the falling edge so data moves only with clock low
            if (scl_fall) begin
              if (ack_good) begin
                sda_oe_r <= 1'b1;
                state_r  <= ST_ACK;
                if (kind_r == KIND_ADDR) begin
                  read_dir_r <= shift_r[0];
                end
              end else begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_IGNORE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt_r <= 3'h0;
              if (kind_r == KIND_ADDR && read_dir_r) begin
                // byte and clear mask from one vector: nothing is cleared unseen
                shift_r  <= status_byte;
                snap_r   <= status_bits;
                sda_oe_r <= ~status_byte[7];
                state_r  <= ST_SEND;
              end else begin
                sda_oe_r <= 1'b0;
                case (kind_r)
                  KIND_ADDR: begin
                    kind_r  <= KIND_INDEX;
                    state_r <= ST_RECV;
                  end
                  KIND_INDEX: begin
                    // index not stored; a repeated start may now turn to a read
                    kind_r  <= KIND_DATA;
                    state_r <= ST_RECV;
                  end
                  default: begin
                    state_r <= ST_IGNORE;
                  end
                endcase
              end
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              if (cnt_r == 3'h7) begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_MACK;
              end else begin
                cnt_r    <= cnt_r + 3'h1;
                shift_r  <= {shift_r[6:0], 1'b0};
                sda_oe_r <= ~shift_r[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              // a negative acknowledge keeps the faults latched
              clear_r <= ~sda_h;
              state_r <= ST_IGNORE;
            end
          end
          ST_IGNORE, ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          default: begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // control register update at the end of its acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ctrl_r     <= CTRL_RESET;
      ctrl_stb_r <= 1'b0;
    end else begin
      ctrl_stb_r <= 1'b0;
      if (!start_cond && !stop_cond && state_r == ST_ACK && kind_r == KIND_DATA
          && scl_fall) begin
        ctrl_r     <= shift_r;
        ctrl_stb_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin outputs, open-drain only, line pulled low while enabled
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      SDA_OUT   <= 1'b0;
      SDA_OE    <= 1'b0;
      SCL_OUT   <= 1'b0;
      SCL_OE    <= 1'b0;
      IRQ_N_OUT <= 1'b0;
      IRQ_N_OE  <= 1'b0;
    end else begin
      SDA_OUT   <= 1'b0;
      SDA_OE    <= sda_oe_r;
      SCL_OUT   <= 1'b0;
      SCL_OE    <= 1'b0;
      IRQ_N_OUT <= 1'b0;
      IRQ_N_OE  <= irq_level;
    end
  end

  // ----------------------------------------------------------------
  // register outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      CONTROL_SETTINGS <= CTRL_RESET;
      CONTROL_STROBE   <= 1'b0;
      FAULT_STATUS     <= 8'h00;
    end else begin
      CONTROL_SETTINGS <= ctrl_r;
      CONTROL_STROBE   <= ctrl_stb_r;
      FAULT_STATUS     <= status_byte;
    end
  end

endmodule : lnbsl_slave

// file: verif/lnbsl_master.sv
`timescale 1ns/1ps
module lnbsl_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam time Q = 40ns;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // ----------------------------------------------------------------
  // conditions; scl stands high between frames
  // ----------------------------------------------------------------
  task automatic start;
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : start

  task automatic stop;
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask : stop

  // ----------------------------------------------------------------
  // bits and bytes
  // ----------------------------------------------------------------
  task automatic bit_x(input logic b, output logic s);
    sda_low = !b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_x

  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(mack, ack);
  endtask : xfer
endmodule : lnbsl_master

// file: verif/lnbsl_slave_asserts.sv
`timescale 1ns/1ps
module lnbsl_slave_asserts
  import lnbsl_pkg::*;
(
  input wire logic       CORE_CLK,
  input wire logic       RESET,
  input wire logic       SCL,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  input wire logic       SCL_OUT,
  input wire logic       SCL_OE,
  input wire logic       UNDERVOLTAGE_FAULT,
  input wire logic [7:0] CONTROL_SETTINGS,
  input wire logic       CONTROL_STROBE,
  input wire logic [7:0] FAULT_STATUS,
  input wire logic       IRQ_N_OUT,
  input wire logic       IRQ_N_OE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_irq_up;
    ##[0:2] IRQ_N_OE;
  endsequence
  sequence s_master_ack;
    $past(SCL, 2) && !$past(SDA_IN, 2);
  endsequence

  a_scl_undriven: assert property (!SCL_OE)
    else $error("clock line driven");
  a_drain_only: assert property (!(SDA_OE && SDA_OUT) && !(IRQ_N_OE && IRQ_N_OUT))
    else $error("line driven high");
  a_sda_low_phase: assert property ($changed(SDA_OE) |-> !SCL && !$past(SCL, 2))
    else $error("data changed with clock high");
  a_strobe_pulse: assert property (CONTROL_STROBE |=> !CONTROL_STROBE)
    else $error("strobe longer than one cycle");
  a_ctrl_strobed: assert property ($changed(CONTROL_SETTINGS) |->
      (##[0:1] CONTROL_STROBE) or ($past(CONTROL_STROBE)))
    else $error("control changed without strobe");
  a_strobe_scl_low: assert property (CONTROL_STROBE |-> !SCL)
    else $error("strobe outside clock low");
  a_fault_set: assert property (UNDERVOLTAGE_FAULT |-> ##[1:5] FAULT_STATUS[STAT_UV_BIT])
    else $error("fault not latched");
  a_irq_rise: assert property ($rose(|FAULT_STATUS) |-> s_irq_up)
    else $error("interrupt not raised");
  a_irq_fall: assert property ($fell(|FAULT_STATUS) |-> ##[0:2] !IRQ_N_OE)
    else $error("interrupt not released");
  a_clear_by_ack: assert property ($fell(|FAULT_STATUS) |-> s_master_ack)
    else $error("status cleared without master ack");
endmodule : lnbsl_slave_asserts

bind lnbsl_slave lnbsl_slave_asserts i_lnbsl_slave_asserts (.CORE_CLK(CORE_CLK),
  .RESET(RESET), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .UNDERVOLTAGE_FAULT(UNDERVOLTAGE_FAULT),
  .CONTROL_SETTINGS(CONTROL_SETTINGS), .CONTROL_STROBE(CONTROL_STROBE),
  .FAULT_STATUS(FAULT_STATUS), .IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE(IRQ_N_OE));

// file: verif/lnbsl_slave_tb.sv
`timescale 1ns/1ps
module lnbsl_slave_tb;
  import lnbsl_pkg::*;
  logic       core_clk = 1'b0, reset = 1'b1, uv = 1'b0, oc = 1'b0, th = 1'b0;
  logic [1:0] addr_sel = 2'b00;
  logic       sda_oe, sda_out, scl_oe, scl_out, strobe, irq_out, irq_oe, m_scl, m_low;
  logic [7:0] ctrl, stat;
  int         n_fail = 0, comparisons = 0, n_strobe = 0;
  // open-drain wires, pulled high when released
  wire        scl_w = m_scl & !(scl_oe & !scl_out);
  wire        sda_w = !m_low & !(sda_oe & !sda_out);
  wire  [6:0] own = {TARGET_ID_FIXED, addr_sel};

  always #2 core_clk = ~core_clk;

  // accepted control writes, counted where the strobe is settled
  always @(negedge core_clk)
    if (strobe === 1'b1) n_strobe++;

  lnbsl_slave i_lnbsl_slave (.CORE_CLK(core_clk), .RESET(reset), .SCL(scl_w), .SDA_IN(sda_w),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
    .ADDR_SEL(addr_sel), .UNDERVOLTAGE_FAULT(uv), .OVERCURRENT_FAULT(oc), .THERMAL_FAULT(th),
    .CONTROL_SETTINGS(ctrl), .CONTROL_STROBE(strobe), .FAULT_STATUS(stat),
    .IRQ_N_OUT(irq_out), .IRQ_N_OE(irq_oe));
  lnbsl_master i_lnbsl_master (.scl(m_scl), .sda_low(m_low), .sda(sda_w));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic do_reset;
    @(negedge core_clk) reset = 1'b1;
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask : do_reset

  task automatic wr(input logic [6:0] id, input logic [7:0] idx, input logic [7:0] d,
                    output logic [2:0] a);
    logic [7:0] r;
    i_lnbsl_master.start();
    i_lnbsl_master.xfer({id, 1'b0}, 1'b1, r, a[2]);
    i_lnbsl_master.xfer(idx, 1'b1, r, a[1]);
    i_lnbsl_master.xfer(d, 1'b1, r, a[0]);
    i_lnbsl_master.stop();
  endtask : wr

  // split: stop between index and repeated address, where the plain read goes straight to a repeated start
  task automatic rd(input logic split, input logic mack, output logic [7:0] d,
                    output logic [2:0] a);
    logic [7:0] r;
    i_lnbsl_master.start();
    i_lnbsl_master.xfer({own, 1'b0}, 1'b1, r, a[2]);
    i_lnbsl_master.xfer(STAT_INDEX, 1'b1, r, a[1]);
    if (split)
      i_lnbsl_master.stop();
    i_lnbsl_master.start();
    i_lnbsl_master.xfer({own, 1'b1}, 1'b1, r, a[0]);
    i_lnbsl_master.xfer(8'hff, mack, d, r[0]);
    i_lnbsl_master.stop();
  endtask : rd

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [2:0] a;
    logic [7:0] d;
    // strap changes only take effect across a reset
    for (int s = 0; s < 4; s++) begin
      addr_sel = s[1:0];
      do_reset();
      chk("ctrl reset", CTRL_RESET, ctrl);
      wr(own, CTRL_INDEX, 8'h5a ^ 8'(s), a);
      chk("write acks", 8'h00, {5'h00, a});
      chk("ctrl", 8'h5a ^ 8'(s), ctrl);
      wr(own ^ 7'h01, CTRL_INDEX, 8'hff, a);
      chk("foreign acks", 8'h07, {5'h00, a});
      chk("ctrl kept", 8'h5a ^ 8'(s), ctrl);
    end
    wr(own, 8'h01, 8'h11, a);
    chk("bad index acks", 8'h03, {5'h00, a});
    chk("ctrl kept", 8'h59, ctrl);
    // abort inside the data byte, first by stop, then by start
    for (int k = 0; k < 2; k++) begin
      i_lnbsl_master.start();
      i_lnbsl_master.xfer({own, 1'b0}, 1'b1, d, a[0]);
      i_lnbsl_master.xfer(CTRL_INDEX, 1'b1, d, a[0]);
      repeat (4) i_lnbsl_master.bit_x(1'b0, a[0]);
      if (k == 0)
        i_lnbsl_master.stop();
    end
    chk("ctrl after abort", 8'h59, ctrl);
    wr(own, CTRL_INDEX, 8'hc3, a);
    chk("acks after abort", 8'h00, {5'h00, a});
    chk("ctrl", 8'hc3, ctrl);
    chk("strobes", 8'h05, 8'(n_strobe));
    for (int k = 0; k < 3; k++) begin
      @(negedge core_clk) {th, oc, uv} = 3'(1 << k);
      repeat (10) @(negedge core_clk);
      {th, oc, uv} = 3'b000;
      repeat (10) @(negedge core_clk);
      chk("status latched", 8'(1 << k), stat);
      chk("irq on", 8'h01, {7'h00, irq_oe});
      rd(k[0], 1'b1, d, a);
      chk("status nak", 8'(1 << k), d);
      chk("kept after nak", 8'(1 << k), stat);
      rd(!k[0], 1'b0, d, a);
      chk("read acks", 8'h00, {5'h00, a});
      chk("status read", 8'(1 << k), d);
      chk("status cleared", 8'h00, stat);
      chk("irq off", 8'h00, {7'h00, irq_oe});
    end
    give_verdict();
  end

  // tests need about 90 us of bus traffic
  initial begin
    #300us;
    n_fail++;
    give_verdict();
  end
endmodule : lnbsl_slave_tb
